// File: rtl/foem_top.v
// Frame overlap and exposure monitor with APB registers
// Notes on behaviour
// - Overlap only when both triggers off and acquisition is continuous.
// - Enabling the sequence feature turns overlap off.
// - Without overlap, a frame's exposure and readout finish before the next.
// - With overlap, the next exposure starts while readout still runs.
// - Frames overlap when period is less than exposure plus readout and readout exceeds the 400 us spacing.
// - Overlap only in line-staggered mode, never simultaneous reset.
// - Alternating sequence sets force non-overlapped operation.
// - Readout time is reported in microseconds.
// - An early frame trigger is discarded and raises an event.
// - Global shutter: indicator spans the frame's exposure time.
// - Line-staggered: indicator spans the first line's exposure.
// - Indicator edges lag actual exposure edges by a fixed delay.
// - Exposure indicator can drive output line 1.
// - Frame-arm indicator shows waiting for a frame trigger.
`include "foem_defines.vh"
module foem_top #(
    parameter TW = 20,
    parameter LAG = `FOEM_IND_LAG
) (
    input wire i_clk,
    input wire i_reset,
    input wire [11:0] i_paddr,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [31:0] i_pwdata,
    input wire [3:0] i_pstrb,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire i_frame_trigger,
    output wire o_exposure_indicator,
    output wire o_frame_arm,
    output wire o_line1,
    output wire o_overlap_active,
    output wire o_readout_active
);
    localparam ST_IDLE = 2'd0;
    localparam ST_EXPO = 2'd1;
    localparam ST_READ = 2'd2;

    reg [7:0] ctrl_r;
    reg [TW-1:0] expo_r;
    reg [TW-1:0] rdout_r;
    reg [TW-1:0] period_r;
    reg line_sel_r;
    reg [1:0] line_src_r;
    reg early_r;
    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [TW-1:0] ecnt_r;
    reg [TW-1:0] rcnt_r;
    reg rd_busy_r;
    reg [TW-1:0] fcnt_r;
    reg [TW-1:0] gap_r;
    reg gap_ok_r;
    reg trg_m_r;
    reg trg_s_r;
    reg trg_d_r;
    wire tick;
    wire trg_edge;
    wire free_run;
    wire overlap_en;
    wire arm;
    wire expo_done;
    wire read_done;
    wire exp_raw;
    wire exp_lag;
    wire wr;
    wire rd;
    wire start;

    foem_us_tick #(
        .DIV(`FOEM_US_CYCLES)
    ) u_tick (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .o_tick(tick)
    );

    // Trigger pin enters through two flops before the edge detector
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            trg_m_r <= 1'b0;
            trg_s_r <= 1'b0;
            trg_d_r <= 1'b0;
        end
        else
        begin
            trg_m_r <= i_frame_trigger;
            trg_s_r <= trg_m_r;
            trg_d_r <= trg_s_r;
        end
    end
    assign trg_edge = trg_s_r & ~trg_d_r;

    // Free run: no triggers, continuous acquisition
    assign free_run = ~ctrl_r[`FOEM_CTRL_ACQ_TRIG]
                    & ~ctrl_r[`FOEM_CTRL_FRM_TRIG]
                    & ctrl_r[`FOEM_CTRL_CONT];
    assign overlap_en = free_run
                      & ~ctrl_r[`FOEM_CTRL_SEQ_EN]
                      & ~ctrl_r[`FOEM_CTRL_SEQ_ALT]
                      & ctrl_r[`FOEM_CTRL_STAGGER];

    assign expo_done = tick && (ecnt_r + 1'b1 >= expo_r);
    assign read_done = tick && (rcnt_r + 1'b1 >= rdout_r);

    // Armed when idle with no readout pending, or when overlap permits it, once the 400 us spacing has passed
    assign arm = ctrl_r[`FOEM_CTRL_ACQ_EN] && st_r != ST_EXPO
               && (overlap_en ? 1'b1 : ~rd_busy_r)
               && gap_ok_r;
    assign start = arm && (ctrl_r[`FOEM_CTRL_FRM_TRIG] ? trg_edge
                   : (fcnt_r + 1'b1 >= period_r && tick));

    // Acquisition sequencer
    always @*
    begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:
                if (start)
                    st_nxt = ST_EXPO;
            ST_EXPO:
                if (expo_done)
                    st_nxt = ST_READ;
            ST_READ:
                if (start)
                    st_nxt = ST_EXPO;
                else if (!rd_busy_r)
                    st_nxt = ST_IDLE;
            default:
                st_nxt = ST_IDLE;
        endcase
    end

    always @(posedge i_clk)
    begin
        if (i_reset)
            st_r <= ST_IDLE;
        else
            st_r <= st_nxt;
    end

    // Exposure, frame-period and 400 us spacing counters in microseconds
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ecnt_r <= {TW{1'b0}};
            fcnt_r <= {TW{1'b0}};
            gap_r <= {TW{1'b0}};
            gap_ok_r <= 1'b1;
        end
        else
        begin
            if (start)
                ecnt_r <= {TW{1'b0}};
            else if (st_r == ST_EXPO && tick)
                ecnt_r <= ecnt_r + 1'b1;
            // Frame period runs from one line-one start to the next
            if (start)
                fcnt_r <= {TW{1'b0}};
            else if (tick && fcnt_r != {TW{1'b1}})
                fcnt_r <= fcnt_r + 1'b1;
            // Spacing window opens at end of line-one exposure
            if (st_r == ST_EXPO && expo_done)
            begin
                gap_r <= {TW{1'b0}};
                gap_ok_r <= 1'b0;
            end
            else if (!gap_ok_r && tick)
            begin
                gap_r <= gap_r + 1'b1;
                if (gap_r + 1'b1 >= `FOEM_GAP_US)
                    gap_ok_r <= 1'b1;
            end
        end
    end

    // Readout runs for the programmed time after exposure ends
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            rcnt_r <= {TW{1'b0}};
            rd_busy_r <= 1'b0;
        end
        else if (st_r == ST_EXPO && expo_done)
        begin
            rcnt_r <= {TW{1'b0}};
            rd_busy_r <= 1'b1;
        end
        else if (rd_busy_r && read_done)
            rd_busy_r <= 1'b0;
        else if (rd_busy_r && tick)
            rcnt_r <= rcnt_r + 1'b1;
    end

    // Global and line-staggered both span the current exposure window
    assign exp_raw = (st_r == ST_EXPO);
    foem_lag #(
        .DEPTH(LAG)
    ) u_lag (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_d(exp_raw),
        .o_q(exp_lag)
    );
    assign o_exposure_indicator = exp_lag;
    assign o_frame_arm = arm;
    assign o_readout_active = rd_busy_r;
    // Overlap flagged while a new exposure runs during the previous readout
    assign o_overlap_active = overlap_en && rd_busy_r
                            && st_r == ST_EXPO;

    // Output line 1 driven only when the selector names it
    assign o_line1 = ~line_sel_r ? 1'b0 :
        (line_src_r == `FOEM_SRC_EXPO) ? exp_lag :
        (line_src_r == `FOEM_SRC_ARM) ? arm :
        (line_src_r == `FOEM_SRC_HIGH);

    // APB: zero wait states, unmapped reads return zero
    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;
    assign wr = i_psel & i_penable & i_pwrite;
    assign rd = i_psel & ~i_pwrite;

    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ctrl_r <= `FOEM_CTRL_RESET;
            expo_r <= `FOEM_EXPO_RESET;
            rdout_r <= `FOEM_RDOUT_RESET;
            period_r <= `FOEM_PERIOD_RESET;
            line_sel_r <= 1'b0;
            line_src_r <= `FOEM_SRC_LOW;
            early_r <= 1'b0;
        end
        else
        begin
            if (wr && i_pstrb[0])
            begin
                case (i_paddr)
                    `FOEM_ADDR_CTRL:
                        ctrl_r <= i_pwdata[7:0];
                    `FOEM_ADDR_LINESEL:
                        line_sel_r <= i_pwdata[0];
                    `FOEM_ADDR_LINESRC:
                        line_src_r <= i_pwdata[1:0];
                    default:
                        ;
                endcase
            end
            if (wr && i_pstrb == 4'hf)
            begin
                case (i_paddr)
                    `FOEM_ADDR_EXPO:
                        expo_r <= i_pwdata[TW-1:0];
                    `FOEM_ADDR_RDOUT:
                        rdout_r <= i_pwdata[TW-1:0];
                    `FOEM_ADDR_PERIOD:
                        period_r <= i_pwdata[TW-1:0];
                    default:
                        ;
                endcase
            end
            // Set wins over a write-one-to-clear in the same cycle
            if (ctrl_r[`FOEM_CTRL_FRM_TRIG] && trg_edge && !arm)
                early_r <= 1'b1;
            else if (wr && i_paddr == `FOEM_ADDR_EVENT && i_pwdata[0])
                early_r <= 1'b0;
        end
    end

    // Read mux, registered during setup so data is stable in access
    always @(posedge i_clk)
    begin
        if (i_reset)
            o_prdata <= 32'h00000000;
        else if (rd && !i_penable)
        begin
            case (i_paddr)
                `FOEM_ADDR_CTRL:
                    o_prdata <= {24'h000000, ctrl_r};
                `FOEM_ADDR_EXPO:
                    o_prdata <= {{(32-TW){1'b0}}, expo_r};
                `FOEM_ADDR_RDOUT:
                    o_prdata <= {{(32-TW){1'b0}}, rdout_r};
                `FOEM_ADDR_STATUS:
                    o_prdata <= {26'h0000000, overlap_en, rd_busy_r,
                                 exp_lag, arm, st_r};
                `FOEM_ADDR_EVENT:
                    o_prdata <= {31'h00000000, early_r};
                `FOEM_ADDR_LINESEL:
                    o_prdata <= {31'h00000000, line_sel_r};
                `FOEM_ADDR_LINESRC:
                    o_prdata <= {30'h00000000, line_src_r};
                `FOEM_ADDR_PERIOD:
                    o_prdata <= {{(32-TW){1'b0}}, period_r};
                default:
                    o_prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// File: rtl/foem_defines.vh
// Register offsets, field positions, reset values and timing counts
`ifndef FOEM_DEFINES_VH
`define FOEM_DEFINES_VH
`define FOEM_ADDR_CTRL 12'h000
`define FOEM_ADDR_EXPO 12'h004
`define FOEM_ADDR_RDOUT 12'h008
`define FOEM_ADDR_STATUS 12'h00c
`define FOEM_ADDR_EVENT 12'h010
`define FOEM_ADDR_LINESEL 12'h014
`define FOEM_ADDR_LINESRC 12'h018
`define FOEM_ADDR_PERIOD 12'h01c
`define FOEM_CTRL_ACQ_TRIG 0
`define FOEM_CTRL_FRM_TRIG 1
`define FOEM_CTRL_CONT 2
`define FOEM_CTRL_SEQ_EN 3
`define FOEM_CTRL_STAGGER 4
`define FOEM_CTRL_GLOBAL 5
`define FOEM_CTRL_SEQ_ALT 6
`define FOEM_CTRL_ACQ_EN 7
`define FOEM_CTRL_RESET 8'h94
`define FOEM_EXPO_RESET 20'h00064
`define FOEM_RDOUT_RESET 20'h000c8
`define FOEM_PERIOD_RESET 20'h00190
`define FOEM_SRC_LOW 2'h0
`define FOEM_SRC_EXPO 2'h1
`define FOEM_SRC_ARM 2'h2
`define FOEM_SRC_HIGH 2'h3
`define FOEM_CLK_MHZ 25
`define FOEM_GAP_US 400
`define FOEM_US_CYCLES `FOEM_CLK_MHZ
`define FOEM_IND_LAG 3
`endif

// File: rtl/foem_us_tick.v
// Microsecond enable pulse divider
`include "foem_defines.vh"
module foem_us_tick #(
    parameter DIV = `FOEM_US_CYCLES
) (
    input wire i_clk,
    input wire i_reset,
    output reg o_tick
);
    reg [7:0] cnt_r;

    // Free-running divider, one-cycle pulse per microsecond
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cnt_r <= 8'h00;
            o_tick <= 1'b0;
        end
        else if (cnt_r == DIV - 1)
        begin
            cnt_r <= 8'h00;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 8'h01;
            o_tick <= 1'b0;
        end
    end
endmodule

// File: rtl/foem_lag.v
// Fixed-length delay line for the exposure indicator
module foem_lag #(
    parameter DEPTH = 3
) (
    input wire i_clk,
    input wire i_reset,
    input wire i_d,
    output wire o_q
);
    reg [DEPTH-1:0] sh_r;

    // Shift register gives the indicator its documented lag
    always @(posedge i_clk)
    begin
        if (i_reset)
            sh_r <= {DEPTH{1'b0}};
        else
            sh_r <= {sh_r[DEPTH-2:0], i_d};
    end
    assign o_q = sh_r[DEPTH-1];
endmodule

// File: verification/foem_properties.sv
// Port-level checker for the frame overlap monitor
module foem_properties (
    input wire i_clk,
    input wire i_reset,
    input wire i_psel,
    input wire i_penable,
    input wire o_pready,
    input wire o_pslverr,
    input wire o_exposure_indicator,
    input wire o_frame_arm,
    input wire o_overlap_active,
    input wire o_readout_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    // Zero wait states: every access phase ends at once
    AST_PREADY: assert property (i_psel && i_penable |-> o_pready)
        else $error("pready low in access");
    AST_NOERR: assert property (!o_pslverr)
        else $error("pslverr high");
    // A frame in exposure never accepts another start
    AST_ARM_EXPO: assert property (
        o_exposure_indicator |-> !o_frame_arm)
        else $error("arm high in exposure");
    // Spacing after each exposure keeps the trigger window shut
    AST_ARM_GAP: assert property (
        $fell(o_exposure_indicator) |-> !o_frame_arm [*8])
        else $error("arm high right after exposure");
    AST_IND_HOLD: assert property (
        $rose(o_exposure_indicator) |=> o_exposure_indicator [*8])
        else $error("indicator pulse too short");
    AST_RD_AFTER: assert property (
        $fell(o_exposure_indicator) |-> o_readout_active)
        else $error("no readout after exposure");
    // Indicator lags, so readout starts while it still shows
    AST_RD_LAG: assert property (
        $rose(o_readout_active) |-> o_exposure_indicator)
        else $error("indicator not lagging");
    AST_OVL: assert property (
        o_overlap_active |-> o_readout_active)
        else $error("overlap without readout");
    // Overlapped exposure reaches the indicator after its fixed lag
    AST_OVL_IND: assert property (
        o_overlap_active |-> ##3 o_exposure_indicator)
        else $error("overlap exposure not shown");
endmodule

// File: verification/foem_trig_src.sv
// Model of the external frame trigger source
module foem_trig_src (
    input wire i_clk,
    input wire i_go,
    input wire i_early,
    input wire i_arm,
    input wire [7:0] i_lag,
    output logic o_trig
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rude;
    initial o_trig = 1'b0;
    // Polite pulses wait for arm, which also keeps the spacing
    // The kind of request is latched at once, as its strobe lasts one cycle
    always @(posedge i_clk)
        if (i_go || i_early)
        begin
            rude = i_early;
            repeat (i_lag) @(posedge i_clk);
            while (!rude && i_arm !== 1'b1)
                @(posedge i_clk);
            o_trig <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_trig <= 1'b0;
        end
endmodule

// File: verification/foem_top_tb.sv
// Self-checking bench for the frame overlap monitor
module foem_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_reset, i_psel, i_penable, i_pwrite;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, r;
    logic o_pready, o_pslverr, trig, ind, arm, line1, ovl, rdo, go, early;
    logic seen;
    logic [7:0] lag;
    logic [31:0] exp_q[$];
    int n_errors, compares, k;
    // Control, period in us, overlap expected, watch span in cycles
    int tbl[6][4] = '{'{8'h94, 20, 1, 12000}, '{8'h94, 700, 0, 18000},
        '{8'h9c, 20, 0, 4000}, '{8'h84, 20, 0, 4000},
        '{8'h90, 20, 0, 4000}, '{8'hd4, 20, 0, 4000}};
    foem_top uut (.i_clk(i_clk), .i_reset(i_reset), .i_paddr(i_paddr),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_pwdata(i_pwdata), .i_pstrb(4'hf), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_frame_trigger(trig),
        .o_exposure_indicator(ind), .o_frame_arm(arm), .o_line1(line1),
        .o_overlap_active(ovl), .o_readout_active(rdo));
    foem_trig_src src (.i_clk(i_clk), .i_go(go), .i_early(early),
        .i_arm(arm), .i_lag(lag), .o_trig(trig));
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task give_verdict();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One APB transfer; an idle cycle follows so no signal is set twice
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        i_paddr <= a;
        i_pwrite <= w;
        i_pwdata <= d;
        i_psel <= 1'b1;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1)
            @(posedge i_clk);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] ex);
        exp_q.push_back(ex);
        apb(a, 1'b0, 32'h0);
    endtask
    task fire(input logic polite);
        if (polite)
            go <= 1'b1;
        else
            early <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        early <= 1'b0;
    endtask
    // Outputs are looked at on the falling edge, where they are settled
    task wait_hi(input logic which, input int lim);
        @(negedge i_clk);
        repeat (lim)
            if ((which ? ind : line1) !== 1'b1)
                @(negedge i_clk);
        chk("wait", 1, which ? ind : line1);
        @(posedge i_clk);
    endtask
    // Read answers are matched to the oldest note
    always @(posedge i_clk)
        if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1)
            chk("prdata", exp_q.pop_front(), o_prdata);
    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // Cut a hang short well beyond the expected run
    initial
    begin
        #(90000 * 40);
        n_errors++;
        give_verdict();
    end
    initial
    begin
        {i_reset, i_psel, i_penable, i_pwrite, go, early} = 6'h20;
        i_paddr = 12'h0;
        i_pwdata = 32'h0;
        k = $urandom(84);
        lag = 8'($urandom % 16);
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(12'h000, 32'h94);
        rd(12'h004, 32'd100);
        rd(12'h008, 32'd200);
        rd(12'h01c, 32'd400);
        rd(12'h010, 32'h0);
        wr(12'h020, 32'hffffffff);
        rd(12'h020, 32'h0);
        $display("test reset values done");
        r = 32'(2 + $urandom % 4);
        wr(12'h004, r);
        rd(12'h004, r);
        wr(12'h000, 32'h92);
        wr(12'h014, 32'h1);
        for (k = 0; k < 2; k++)
        begin
            wr(12'h018, 32'(k * 3));
            chk("line1 fixed", 32'(k), line1);
        end
        wr(12'h018, 32'h2);
        chk("line1 arm", 1, line1);
        rd(12'h00c, 32'h4);
        wr(12'h018, 32'h1);
        fire(1'b1);
        wait_hi(1'b0, 2000);
        fire(1'b0);
        repeat (20) @(posedge i_clk);
        rd(12'h010, 32'h1);
        rd(12'h010, 32'h1);
        wr(12'h010, 32'h1);
        rd(12'h010, 32'h0);
        fire(1'b1);
        wait_hi(1'b1, 30000);
        rd(12'h010, 32'h0);
        $display("test trigger spacing done");
        wr(12'h004, 32'd20);
        // Readout beyond the 400 us spacing lets frames overlap
        wr(12'h008, 32'd600);
        rd(12'h008, 32'd600);
        for (k = 0; k < 6; k++)
        begin
            wr(12'h01c, 32'(tbl[k][1]));
            wr(12'h000, 32'(tbl[k][0]));
            repeat (1000) @(posedge i_clk);
            seen = 1'b0;
            repeat (tbl[k][3]) @(negedge i_clk) seen = seen | ovl;
            @(posedge i_clk);
            chk("overlap", 32'(tbl[k][2]), 32'(seen));
        end
        $display("test overlap modes done");
        give_verdict();
    end
endmodule
bind foem_top foem_properties chk_i (.i_clk(i_clk), .i_reset(i_reset),
    .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_exposure_indicator(o_exposure_indicator),
    .o_frame_arm(o_frame_arm), .o_overlap_active(o_overlap_active),
    .o_readout_active(o_readout_active));
